/* File: sub_irq_consts.svh */
/*
  Offsets, field positions and reset values for the
  sub-source interrupt stage.
  Assumes a 32-bit Avalon-MM register bus with byte addresses.
*/
`ifndef SUB_IRQ_CONSTS_SVH
`define SUB_IRQ_CONSTS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define SUB_PEND_OFFSET   32'h4a00_0018
`define SUB_MASK_OFFSET   32'h4a00_001c
`define SUB_ADDR_LSB_MASK 32'h0000_00ff

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SUB_COUNT         11
`define SUB_BIT_S0_RX     0
`define SUB_BIT_S0_TX     1
`define SUB_BIT_S0_ERR    2
`define SUB_BIT_S1_RX     3
`define SUB_BIT_S1_TX     4
`define SUB_BIT_S1_ERR    5
`define SUB_BIT_S2_RX     6
`define SUB_BIT_S2_TX     7
`define SUB_BIT_S2_ERR    8
`define SUB_BIT_TOUCH     9
`define SUB_BIT_CONV      10

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SUB_PEND_RESET    11'h000
`define SUB_MASK_RESET    11'h7ff
`define SUB_READ_UNMAPPED 32'h0000_0000

`endif

/* File: sub_irq_pkg.sv */
/*
  Types shared by the sub-source interrupt stage.
  Assumes the constants header is compiled alongside.
*/
package sub_irq_pkg;

  // Request side of the register bus, grouped
  typedef struct packed {
    logic        read;
    logic        write;
    logic [31:0] address;
    logic [31:0] writedata;
  } bus_req_t;

  // Forwarded requests towards the main pending logic
  typedef struct packed {
    logic converter;
    logic serial2;
    logic serial1;
    logic serial0;
  } main_req_t;

  // Bus slave phase
  typedef enum logic [0:0] {
    BUS_IDLE,
    BUS_DONE
  } bus_state_t;

endpackage

/* File: sub_irq_sync.sv */
/*
  Two-flop level synchroniser, one instance per request line.
  Assumes the input may change at any time relative to clk.
*/
`timescale 1ns/10ps
`default_nettype none

module sub_irq_sync
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Asynchronous level in, synchronised level out
  input  wire logic async_in,
  output var  logic sync_out
);

  logic stage1;

  // First flop feeds only the second, to keep metastability contained
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1   <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule
`default_nettype wire

/* File: sub_irq_stage.sv */
/*
  Second-level interrupt stage: eleven sticky sub-source pending bits, a
  mask, an Avalon-MM slave for both registers and the per-port requests
  handed to the main pending logic.
  Assumes sub-request lines come from peripheral logic that may be on
  another clock; each is synchronised before use.
*/
// Chosen here: the Avalon-MM slave port.
// Operation
// - Writing one clears pending; zero keeps it
// - Pending sets on request; resets to zero
// - Bits 0-8 serial rx/tx/err; 9 touch, 10 converter
// - Only eleven bits; 31:11 read zero
// - Masked source not forwarded, still pending
// - Unmasked pending source is forwarded
// - Mask resets to all eleven set
`timescale 1ns/10ps
`default_nettype none
`include "sub_irq_consts.svh"

module sub_irq_stage
#(
  parameter int SUB_COUNT = `SUB_COUNT
)
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // Avalon-MM slave
  input  wire logic [31:0]           avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output var  logic [31:0]           avs_readdata,
  output var  logic                  avs_waitrequest,
  // Peripheral sub-requests, level, from other clock domains
  input  wire logic [SUB_COUNT-1:0]  sub_request,
  // Requests towards the main pending logic
  output var  sub_irq_pkg::main_req_t main_request,
  // Register views for the main logic
  output var  logic [SUB_COUNT-1:0]  sub_source_pending,
  output var  logic [SUB_COUNT-1:0]  sub_source_mask
);

  // The bit layout is fixed at eleven sources
  if (SUB_COUNT != `SUB_COUNT)
  begin : g_bad_count
    $error("sub_irq_stage serves exactly eleven sub-sources");
  end

  // ----------------------------------------------------------------------
  // Request synchronisers and edge detection
  // ----------------------------------------------------------------------
  logic [SUB_COUNT-1:0] req_sync;
  logic [SUB_COUNT-1:0] req_prev;
  logic [SUB_COUNT-1:0] req_rise;

  for (genvar i = 0; i < SUB_COUNT; i++)
  begin : g_sync
    sub_irq_sync u_sync
    (
      .clk      (clk),
      .rst_n    (rst_n),
      .async_in (sub_request[i]),
      .sync_out (req_sync[i])
    );
  end

  // Previous synchronised level, for rising-edge events
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      req_prev <= '0;
    else
      req_prev <= req_sync;
  end

  // Edge, not level: a held request does not re-set a cleared bit
  assign req_rise = req_sync & ~req_prev;

  // ----------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------
  sub_irq_pkg::bus_req_t   bus;
  sub_irq_pkg::bus_state_t bus_state;
  logic                    hit_pend;
  logic                    hit_mask;
  logic                    wr_take;
  logic                    low_lane;
  logic                    high_lane;

  // Bus request gathered into one carrier
  assign bus.read      = avs_read;
  assign bus.write     = avs_write;
  assign bus.address   = avs_address;
  assign bus.writedata = avs_writedata;

  // Lanes 2 and 3 carry only reserved bits, so their enables are ignored
  assign hit_pend  = (bus.address == `SUB_PEND_OFFSET);
  assign hit_mask  = (bus.address == `SUB_MASK_OFFSET);
  assign low_lane  = avs_byteenable[0];
  assign high_lane = avs_byteenable[1];

  // Every access answers one cycle after it is seen; waitrequest drops then
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      bus_state <= sub_irq_pkg::BUS_IDLE;
    else
    begin
      case (bus_state)
        sub_irq_pkg::BUS_IDLE:
          if (bus.read || bus.write)
            bus_state <= sub_irq_pkg::BUS_DONE;
        sub_irq_pkg::BUS_DONE:
          bus_state <= sub_irq_pkg::BUS_IDLE;
        default:
          bus_state <= sub_irq_pkg::BUS_IDLE;
      endcase
    end
  end

  // Waitrequest high by default, low for the single completing cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= !((bus_state == sub_irq_pkg::BUS_IDLE) && (bus.read || bus.write));
  end

  // A write takes effect on the edge where waitrequest is sampled low
  assign wr_take = bus.write && (bus_state == sub_irq_pkg::BUS_DONE);

  // ----------------------------------------------------------------------
  // Pending and mask registers
  // ----------------------------------------------------------------------
  logic [SUB_COUNT-1:0] clear_bits;
  logic [SUB_COUNT-1:0] next_pending;

  // Byte lanes: bits 7:0 on lane 0, bits 10:8 on lane 1
  assign clear_bits = (wr_take && hit_pend) ?
                      {bus.writedata[10:8] & {3{high_lane}},
                       bus.writedata[7:0] & {8{low_lane}}} : '0;

  // set on request, set wins over clear
  assign next_pending = (sub_source_pending & ~clear_bits) | req_rise;

  // Pending bits, zero after reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sub_source_pending <= `SUB_PEND_RESET;
    else
      sub_source_pending <= next_pending;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sub_source_mask <= `SUB_MASK_RESET;
    else if (wr_take && hit_mask)
    begin
      if (low_lane)
        sub_source_mask[7:0] <= bus.writedata[7:0];
      if (high_lane)
        sub_source_mask[10:8] <= bus.writedata[10:8];
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  // upper bits read zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      avs_readdata <= `SUB_READ_UNMAPPED;
    else if ((bus_state == sub_irq_pkg::BUS_IDLE) && bus.read)
    begin
      if (hit_pend)
        avs_readdata <= {21'h0, next_pending};
      else if (hit_mask)
        avs_readdata <= {21'h0, sub_source_mask};
      else
        avs_readdata <= `SUB_READ_UNMAPPED; // Unmapped reads give zero
    end
  end

  // ----------------------------------------------------------------------
  // Forwarding to the main logic
  // ----------------------------------------------------------------------
  // Pending is taken as it will stand after this edge, the mask as it stood
  // before it, so a mask write reaches the main logic one cycle after it lands
  logic [SUB_COUNT-1:0] live;

  assign live = next_pending & ~sub_source_mask;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      main_request <= '0;
    else
    begin
      main_request.serial0   <= |live[`SUB_BIT_S0_ERR:`SUB_BIT_S0_RX];
      main_request.serial1   <= |live[`SUB_BIT_S1_ERR:`SUB_BIT_S1_RX];
      main_request.serial2   <= |live[`SUB_BIT_S2_ERR:`SUB_BIT_S2_RX];
      main_request.converter <= live[`SUB_BIT_TOUCH] | live[`SUB_BIT_CONV];
    end
  end

endmodule
`default_nettype wire

/* File: sub_irq_stage_properties.sv */
/*
  Port checker for the sub-source interrupt stage.
  Assumes a bind onto sub_irq_stage and a single clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module sub_irq_stage_chk
#(
  parameter int SUB_COUNT = 11
)
(
  // Clock, reset and bus
  input wire logic                   clk,
  input wire logic                   rst_n,
  input wire logic [31:0]            avs_address,
  input wire logic                   avs_read,
  input wire logic                   avs_write,
  input wire logic [31:0]            avs_writedata,
  input wire logic [3:0]             avs_byteenable,
  input wire logic [31:0]            avs_readdata,
  input wire logic                   avs_waitrequest,
  // Requests and register views
  input wire logic [SUB_COUNT-1:0]   sub_request,
  input wire sub_irq_pkg::main_req_t main_request,
  input wire logic [SUB_COUNT-1:0]   sub_source_pending,
  input wire logic [SUB_COUNT-1:0]   sub_source_mask
);
  // ----------
  // Properties
  // ----------
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Write accepted at this edge
  wire logic wr_ok = avs_write && !avs_waitrequest;
  // Forwarded value may lag a change by one edge, so judge it once calm
  sequence s_calm;
    $stable(sub_source_pending) && $stable(sub_source_mask);
  endsequence
  property p_pend_rst; $rose(rst_n) |-> sub_source_pending == '0; endproperty
  property p_mask_rst; $rose(rst_n) |-> &sub_source_mask; endproperty
  property p_set; $rose(sub_request[10]) |-> ##[2:4] sub_source_pending[10]; endproperty
  property p_keep;
    wr_ok |=> ($past(sub_source_pending) & ~$past(avs_writedata[SUB_COUNT-1:0])
      & ~sub_source_pending) == '0;
  endproperty
  property p_hi_zero; avs_read && !avs_waitrequest |-> avs_readdata[31:11] == '0; endproperty
  property p_mask_wr;
    wr_ok && avs_address == 32'h4a00_001c && &avs_byteenable
      |=> sub_source_mask == $past(avs_writedata[SUB_COUNT-1:0]);
  endproperty
  property p_serial0;
    s_calm |-> main_request.serial0 == |(sub_source_pending[2:0] & ~sub_source_mask[2:0]);
  endproperty
  property p_conv;
    s_calm |-> main_request.converter == |(sub_source_pending[10:9] & ~sub_source_mask[10:9]);
  endproperty
  property p_masked; s_calm ##0 &sub_source_mask |-> main_request == '0; endproperty
  property p_fwd;
    s_calm ##0 (sub_source_pending[3] && !sub_source_mask[3]) |-> main_request.serial1;
  endproperty
  a_pend_rst: assert property (p_pend_rst) else $error("pending not zero");
  a_mask_rst: assert property (p_mask_rst) else $error("mask not all set");
  a_set: assert property (p_set) else $error("pending not set");
  a_keep: assert property (p_keep) else $error("pending lost a bit");
  a_hi_zero: assert property (p_hi_zero) else $error("upper bits set");
  a_mask_wr: assert property (p_mask_wr) else $error("mask not written");
  a_serial0: assert property (p_serial0) else $error("serial0 wrong");
  a_conv: assert property (p_conv) else $error("converter wrong");
  a_masked: assert property (p_masked) else $error("masked forwarded");
  a_fwd: assert property (p_fwd) else $error("serial1 not forwarded");
  c_clear: cover property (wr_ok && avs_address == 32'h4a00_0018);
  c_fwd: cover property (main_request.serial2);
  c_held: cover property (&sub_source_mask && sub_source_pending != '0);
endmodule
bind sub_irq_stage sub_irq_stage_chk #(.SUB_COUNT(SUB_COUNT)) u_chk
(
  .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .sub_request(sub_request), .main_request(main_request),
  .sub_source_pending(sub_source_pending), .sub_source_mask(sub_source_mask)
);
`default_nettype wire

/* File: sub_irq_peer.sv */
/*
  Peripheral side: drives the eleven sub-request levels.
  Assumes the bench commands which lines stand high.
*/
`timescale 1ns/10ps
`default_nettype none
module sub_irq_peer
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Command and pace from the bench
  input  wire logic [10:0] cmd,
  input  wire logic        slow,
  // Request levels
  output var  logic [10:0] sub_request
);
  logic [10:0] late;
  // A slow peripheral raises its lines one cycle later
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      late        <= 11'h000;
      sub_request <= 11'h000;
    end
    else
    begin
      late        <= cmd;
      sub_request <= slow ? late : cmd;
    end
  end
endmodule
`default_nettype wire

/* File: tb_top.sv */
/*
  Self-checking bench for the sub-source interrupt stage.
  Assumes the stage, its checker and the peer model.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  // -------
  // Signals
  // -------
  logic        clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, slow = 1'b0;
  logic [31:0] addr = '0, wdata = '0, rdat, d, seed = 32'h0000_3e4b;
  logic [10:0] cmd = '0, pend_m, mask_m, r, pend, mask;
  logic [31:0] rdata;
  logic        waitreq;
  logic [10:0] req;
  logic [3:0]  be = 4'hf;
  sub_irq_pkg::main_req_t main;
  int          fails = 0, tests_run = 0;
  sub_irq_stage #(.SUB_COUNT(11)) DUT
  (
    .clk(clk), .rst_n(rst_n), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(waitreq), .sub_request(req), .main_request(main),
    .sub_source_pending(pend), .sub_source_mask(mask)
  );
  sub_irq_peer peer (.clk(clk), .rst_n(rst_n), .cmd(cmd), .slow(slow), .sub_request(req));
  // Clock
  initial
  begin
    forever #5 clk = ~clk;
  end
  // Watchdog, far beyond the few hundred cycles the tests need
  initial
  begin
    #100000;
    fails++;
    print_verdict();
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected forwarded requests, one per port and the converter pair
  function automatic logic [31:0] exp_main(input logic [10:0] p, input logic [10:0] m);
    logic [10:0] u;
    u = p & ~m;
    return {28'h000_0000, |u[10:9], |u[8:6], |u[5:3], |u[2:0]};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] v);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= v;
    do @(posedge clk); while (waitreq !== 1'b0);
    rdat = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Reset values, an unmapped place, then random rounds
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, 32'h4a00_0018, 32'h0); chk("pending", 32'h0, rdat);
    bus(1'b0, 32'h4a00_001c, 32'h0); chk("mask", 32'h0000_07ff, rdat);
    bus(1'b1, 32'h4a00_0020, 32'hffff_ffff);
    bus(1'b0, 32'h4a00_0020, 32'h0); chk("unmapped", 32'h0, rdat);
    pend_m = '0;
    mask_m = 11'h7ff;
    for (int i = 0; i < 12; i++)
    begin
      d = xs();
      r = (i == 0) ? 11'h7ff : d[10:0];
      slow <= d[20];
      cmd <= '0;
      repeat (4) @(posedge clk);
      cmd <= r;
      repeat (8) @(posedge clk);
      pend_m = pend_m | r;
      bus(1'b0, 32'h4a00_0018, 32'h0); chk("pending", {21'h0, pend_m}, rdat);
      chk("pending port", {21'h0, pend_m}, pend);
      chk("main", exp_main(pend_m, mask_m), main);
      d = xs();
      // Odd rounds write the mask with random enables on the two low byte lanes only
      if (i[0])
      begin
        mask_m = {(d[16] ? d[10:8] : mask_m[10:8]), (d[15] ? d[7:0] : mask_m[7:0])};
        be <= {2'b00, d[16:15]};
      end
      else
      begin
        mask_m = d[10:0];
        be <= 4'hf;
      end
      bus(1'b1, 32'h4a00_001c, d);
      be <= 4'hf;
      bus(1'b0, 32'h4a00_001c, 32'h0); chk("mask", {21'h0, mask_m}, rdat);
      chk("mask port", {21'h0, mask_m}, mask);
      chk("main", exp_main(pend_m, mask_m), main);
      d = xs();
      pend_m = pend_m & ~d[10:0];
      bus(1'b1, 32'h4a00_0018, d);
      bus(1'b0, 32'h4a00_0018, 32'h0); chk("cleared", {21'h0, pend_m}, rdat);
      chk("main", exp_main(pend_m, mask_m), main);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
